/* File: hdl/ssq_map.vh */
// constants for the status filter, questionable group and error queue block
// assumes inclusion by ssq_status.v only
`ifndef SSQ_MAP_VH
`define SSQ_MAP_VH

// ----------------------------------------------------------------
// command opcodes
// ----------------------------------------------------------------
`define SSQ_OP_W          4
`define SSQ_OP_NOP        4'h0
`define SSQ_OP_OPER_RISE_WR 4'h1
`define SSQ_OP_OPER_RISE_RD 4'h2
`define SSQ_OP_OPER_FALL_WR 4'h3
`define SSQ_OP_OPER_FALL_RD 4'h4
`define SSQ_OP_PRESET     4'h5
`define SSQ_OP_WARN_EV_RD 4'h6
`define SSQ_OP_WARN_CND_RD 4'h7
`define SSQ_OP_WARN_MSK_WR 4'h8
`define SSQ_OP_WARN_MSK_RD 4'h9
`define SSQ_OP_WARN_RISE_WR 4'hA
`define SSQ_OP_WARN_RISE_RD 4'hB
`define SSQ_OP_WARN_FALL_WR 4'hC
`define SSQ_OP_WARN_FALL_RD 4'hD
`define SSQ_OP_QUEUE_POP  4'hE
`define SSQ_OP_SYS_ERR_POP 4'hF

// ----------------------------------------------------------------
// reset and preset values
// ----------------------------------------------------------------
`define SSQ_RISE_RST      15'h7FFF
`define SSQ_FALL_RST      15'h0000
`define SSQ_MASK_RST      15'h0000
`define SSQ_ZERO15        15'h0000

// ----------------------------------------------------------------
// named status bits
// ----------------------------------------------------------------
`define SSQ_OPER_SELFTEST_BIT 9
`define SSQ_OPER_SWEEP_BIT    3
`define SSQ_WARN_UNLEVEL_BIT  3
`define SSQ_WARN_LOCK_BIT     5
`define SSQ_WARN_STFAIL_BIT   9
`define SSQ_SUMMARY_ERRQ_BIT  2

// ----------------------------------------------------------------
// error queue
// ----------------------------------------------------------------
`define SSQ_QDEPTH        10
`define SSQ_NO_ERR_CODE   16'h0000
`define SSQ_NO_ERR_DESC   8'h00
`define SSQ_OVF_CODE      16'hFEA2
`define SSQ_OVF_DESC      8'h01

`endif

/* File: hdl/ssq_status.v */
// status transition filters, questionable group and error queue
// assumes a command decoder upstream issuing one opcode per cycle
// What this block does
// - operational rise filter, 15 bits writable, powers up all ones.
// - operational condition rising with rise-filter bit set raises that event bit.
// - operational fall filter, 15 bits writable, powers up zero.
// - operational condition falling with fall-filter bit set raises that event bit.
// - preset clears enables, rise filters to ones, fall filters to zero, both groups.
// - reading questionable event returns contents then clears it.
// - reading questionable condition returns live bits, nothing changes.
// - questionable enable mask, 15 bits writable, powers up zero.
// - questionable bit 5 is lock error; its enable bit unmasks it.
// - questionable rise filter, 15 bits writable, powers up all ones.
// - questionable condition rising with rise-filter bit set latches event bit.
// - questionable fall filter, 15 bits writable, powers up zero.
// - questionable bit 3 unleveled; falling with fall filter set latches event.
// - detected errors enter a ten-deep first-in first-out queue, code plus description.
// - queue read returns oldest entry and removes it; both queries pop it.
// - summary bit 2 set while queue holds entries, clear when empty.
// - empty queue read answers code zero; controller repeats reads to drain.
// - push into full queue with no pop that cycle overwrites newest entry with code -350.
// - every enable and transition mask reads back last written or preset value.
`timescale 1ns/1ps
`include "ssq_map.vh"

module ssq_status #(
  parameter QDEPTH = `SSQ_QDEPTH,
  parameter PTR_W  = 4,
  parameter CODE_W = 16,
  parameter DESC_W = 8
) (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                cmd_valid,
  input  wire [3:0]          cmd_op,
  input  wire [14:0]         cmd_wdata,
  input  wire [14:0]         oper_cond_in,
  input  wire [14:0]         warn_cond_in,
  input  wire                err_push,
  input  wire [CODE_W-1:0]   err_code,
  input  wire [DESC_W-1:0]   err_desc,
  output reg                 rsp_valid_q,
  output reg  [14:0]         rsp_data_q,
  output reg  [CODE_W-1:0]   rsp_code_q,
  output reg  [DESC_W-1:0]   rsp_desc_q,
  output reg  [14:0]         oper_event_set_q,
  output reg                 oper_enable_clr_q,
  output reg  [14:0]         warn_cond_q,
  output reg                 warn_summary_q,
  output reg                 lock_err_flag_q,
  output reg                 err_avail_q
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg  [14:0]        oper_rise_filter_q;
  reg  [14:0]        oper_fall_filter_q;
  reg  [14:0]        oper_cond_q;
  reg  [14:0]        warn_event_latch_q;
  reg  [14:0]        warn_event_mask_q;
  reg  [14:0]        warn_rise_filter_q;
  reg  [14:0]        warn_fall_filter_q;
  reg  [CODE_W-1:0]  q_code_mem [0:QDEPTH-1];
  reg  [DESC_W-1:0]  q_desc_mem [0:QDEPTH-1];
  reg  [PTR_W-1:0]   wr_ptr_q;
  reg  [PTR_W-1:0]   rd_ptr_q;
  reg  [PTR_W-1:0]   count_q;
  reg  [PTR_W-1:0]   count_d;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire               cmd_preset;
  wire               cmd_pop;
  wire               cmd_ev_rd;
  wire               q_empty;
  wire               q_full;
  wire               do_pop;
  wire               do_push;
  wire               do_ovf;
  wire [14:0]        oper_rise;
  wire [14:0]        oper_fall;
  wire [14:0]        warn_rise;
  wire [14:0]        warn_fall;
  wire [14:0]        warn_event_d;
  wire [PTR_W-1:0]   wr_ptr_inc;
  wire [PTR_W-1:0]   rd_ptr_inc;
  wire [PTR_W-1:0]   newest_ptr;
  wire [PTR_W-1:0]   last_idx;
  wire [31:0]        qdepth_full;
  wire [31:0]        last_full;
  wire               mem_wr_en;
  wire [PTR_W-1:0]   mem_wr_idx;
  wire [CODE_W-1:0]  mem_wr_code;
  wire [DESC_W-1:0]  mem_wr_desc;
  wire [CODE_W-1:0]  head_code;
  wire [DESC_W-1:0]  head_desc;
  reg  [14:0]        rd_mux;

  // depth arrives as a 32-bit parameter; pointers keep only their own bits
  assign qdepth_full = QDEPTH;
  assign last_full   = QDEPTH - 1;
  assign last_idx    = last_full[PTR_W-1:0];
  assign cmd_preset = cmd_valid && (cmd_op == `SSQ_OP_PRESET);
  // both queue queries share one pop path
  assign cmd_pop    = cmd_valid && ((cmd_op == `SSQ_OP_QUEUE_POP) || (cmd_op == `SSQ_OP_SYS_ERR_POP));
  assign cmd_ev_rd  = cmd_valid && (cmd_op == `SSQ_OP_WARN_EV_RD);

  // ----------------------------------------------------------------
  // transition detection
  // ----------------------------------------------------------------
  // first cycle after reset sees every high input as a rise
  // both groups share one filter shape
  ssq_edge_filter #(
    .W (15)
  ) u_oper_filter (
    .cond_now  (oper_cond_in),
    .cond_prev (oper_cond_q),
    .rise_mask (oper_rise_filter_q),
    .fall_mask (oper_fall_filter_q),
    .rise_hit  (oper_rise),
    .fall_hit  (oper_fall)
  );

  ssq_edge_filter #(
    .W (15)
  ) u_warn_filter (
    .cond_now  (warn_cond_in),
    .cond_prev (warn_cond_q),
    .rise_mask (warn_rise_filter_q),
    .fall_mask (warn_fall_filter_q),
    .rise_hit  (warn_rise),
    .fall_hit  (warn_fall)
  );

  // a transition arriving with the clearing read survives it
  assign warn_event_d = (cmd_ev_rd ? `SSQ_ZERO15 : warn_event_latch_q) | warn_rise | warn_fall;

  // ----------------------------------------------------------------
  // condition and event registers
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oper_cond_q        <= `SSQ_ZERO15;
      warn_cond_q        <= `SSQ_ZERO15;
      warn_event_latch_q <= `SSQ_ZERO15;
      oper_event_set_q   <= `SSQ_ZERO15;
      warn_summary_q     <= 1'b0;
      lock_err_flag_q    <= 1'b0;
    end else begin
      oper_cond_q        <= oper_cond_in;
      warn_cond_q        <= warn_cond_in;
      warn_event_latch_q <= warn_event_d;
      oper_event_set_q   <= oper_rise | oper_fall;
      warn_summary_q     <= |(warn_event_d & warn_event_mask_q);
      lock_err_flag_q    <= warn_event_d[`SSQ_WARN_LOCK_BIT] & warn_event_mask_q[`SSQ_WARN_LOCK_BIT];
    end
  end

  // ----------------------------------------------------------------
  // masks and filters
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oper_rise_filter_q <= `SSQ_RISE_RST;
      oper_fall_filter_q <= `SSQ_FALL_RST;
      warn_event_mask_q  <= `SSQ_MASK_RST;
      warn_rise_filter_q <= `SSQ_RISE_RST;
      warn_fall_filter_q <= `SSQ_FALL_RST;
      oper_enable_clr_q  <= 1'b0;
    end else begin
      oper_enable_clr_q <= cmd_preset;
      if (cmd_preset) begin
        oper_rise_filter_q <= `SSQ_RISE_RST;
        oper_fall_filter_q <= `SSQ_FALL_RST;
        warn_event_mask_q  <= `SSQ_MASK_RST;
        warn_rise_filter_q <= `SSQ_RISE_RST;
        warn_fall_filter_q <= `SSQ_FALL_RST;
      end else if (cmd_valid) begin
        case (cmd_op)
          `SSQ_OP_OPER_RISE_WR: begin
            oper_rise_filter_q <= cmd_wdata;
          end
          `SSQ_OP_OPER_FALL_WR: begin
            oper_fall_filter_q <= cmd_wdata;
          end
          `SSQ_OP_WARN_MSK_WR: begin
            warn_event_mask_q <= cmd_wdata;
          end
          `SSQ_OP_WARN_RISE_WR: begin
            warn_rise_filter_q <= cmd_wdata;
          end
          `SSQ_OP_WARN_FALL_WR: begin
            warn_fall_filter_q <= cmd_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // error queue
  // ----------------------------------------------------------------
  assign q_empty    = (count_q == {PTR_W{1'b0}});
  assign q_full     = (count_q == qdepth_full[PTR_W-1:0]);
  assign do_pop     = cmd_pop && !q_empty;
  // a pop in the same cycle frees a slot, so no overflow then
  assign do_push    = err_push && (!q_full || do_pop);
  assign do_ovf     = err_push && q_full && !do_pop;
  assign wr_ptr_inc = (wr_ptr_q == last_idx) ? {PTR_W{1'b0}} : wr_ptr_q + 1'b1;
  assign rd_ptr_inc = (rd_ptr_q == last_idx) ? {PTR_W{1'b0}} : rd_ptr_q + 1'b1;
  assign newest_ptr = (wr_ptr_q == {PTR_W{1'b0}}) ? last_idx : wr_ptr_q - 1'b1;

  // overflow reuses the write port, aimed at the newest slot
  assign mem_wr_en   = do_push || do_ovf;
  assign mem_wr_idx  = do_push ? wr_ptr_q : newest_ptr;
  assign mem_wr_code = do_push ? err_code : `SSQ_OVF_CODE;
  assign mem_wr_desc = do_push ? err_desc : `SSQ_OVF_DESC;

  // storage carries no reset; the read pointer and count_q say what is valid
  always @(posedge clk) begin
    if (mem_wr_en) begin
      q_code_mem[mem_wr_idx] <= mem_wr_code;
      q_desc_mem[mem_wr_idx] <= mem_wr_desc;
    end
  end

  // ----------------------------------------------------------------
  // queue occupancy
  // ----------------------------------------------------------------
  always @* begin
    count_d = count_q;
    if (do_push && !do_pop) begin
      count_d = count_q + 1'b1;
    end else if (do_pop && !do_push) begin
      count_d = count_q - 1'b1;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_q    <= {PTR_W{1'b0}};
      rd_ptr_q    <= {PTR_W{1'b0}};
      count_q     <= {PTR_W{1'b0}};
      err_avail_q <= 1'b0;
    end else begin
      if (do_push) begin
        wr_ptr_q <= wr_ptr_inc;
      end
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_inc;
      end
      count_q     <= count_d;
      // summary bit follows the count as it will be next cycle
      err_avail_q <= (count_d != {PTR_W{1'b0}});
    end
  end

  // ----------------------------------------------------------------
  // query answers
  // ----------------------------------------------------------------
  // oldest entry, read in place without a staging register
  assign head_code = q_code_mem[rd_ptr_q];
  assign head_desc = q_desc_mem[rd_ptr_q];

  always @* begin
    rd_mux = `SSQ_ZERO15;
    case (cmd_op)
      `SSQ_OP_OPER_RISE_RD: begin
        rd_mux = oper_rise_filter_q;
      end
      `SSQ_OP_OPER_FALL_RD: begin
        rd_mux = oper_fall_filter_q;
      end
      `SSQ_OP_WARN_EV_RD: begin
        rd_mux = warn_event_latch_q;
      end
      `SSQ_OP_WARN_CND_RD: begin
        rd_mux = warn_cond_q;
      end
      `SSQ_OP_WARN_MSK_RD: begin
        rd_mux = warn_event_mask_q;
      end
      `SSQ_OP_WARN_RISE_RD: begin
        rd_mux = warn_rise_filter_q;
      end
      `SSQ_OP_WARN_FALL_RD: begin
        rd_mux = warn_fall_filter_q;
      end
      default: begin
        rd_mux = `SSQ_ZERO15;
      end
    endcase
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= `SSQ_ZERO15;
      rsp_code_q  <= `SSQ_NO_ERR_CODE;
      rsp_desc_q  <= `SSQ_NO_ERR_DESC;
    end else begin
      rsp_valid_q <= cmd_valid && (cmd_op != `SSQ_OP_NOP);
      if (cmd_valid) begin
        rsp_data_q <= rd_mux;
      end
      if (cmd_pop) begin
        if (q_empty) begin
          rsp_code_q <= `SSQ_NO_ERR_CODE;
          rsp_desc_q <= `SSQ_NO_ERR_DESC;
        end else begin
          rsp_code_q <= head_code;
          rsp_desc_q <= head_desc;
        end
      end
    end
  end

endmodule

// ----------------------------------------------------------------
// transition filter, one per status group
// ----------------------------------------------------------------
module ssq_edge_filter #(
  parameter W = 15
) (
  input  wire [W-1:0] cond_now,
  input  wire [W-1:0] cond_prev,
  input  wire [W-1:0] rise_mask,
  input  wire [W-1:0] fall_mask,
  output wire [W-1:0] rise_hit,
  output wire [W-1:0] fall_hit
);

  // combinational only; the caller owns the previous-cycle copy
  assign rise_hit = cond_now & ~cond_prev & rise_mask;
  assign fall_hit = ~cond_now & cond_prev & fall_mask;

endmodule

/* File: tb/ssq_status_checker.sv */
// port assertions for the status block
// assumes bind onto ssq_status, single clock
`timescale 1ns/1ps
module ssq_status_checker #(
  parameter QDEPTH = 10,
  parameter PTR_W  = 4,
  parameter CODE_W = 16,
  parameter DESC_W = 8
) (
  input wire              clk,
  input wire              rst_n,
  input wire              cmd_valid,
  input wire [3:0]        cmd_op,
  input wire [14:0]       cmd_wdata,
  input wire [14:0]       oper_cond_in,
  input wire [14:0]       warn_cond_in,
  input wire              err_push,
  input wire [CODE_W-1:0] err_code,
  input wire [DESC_W-1:0] err_desc,
  input wire              rsp_valid_q,
  input wire [14:0]       rsp_data_q,
  input wire [CODE_W-1:0] rsp_code_q,
  input wire [DESC_W-1:0] rsp_desc_q,
  input wire [14:0]       oper_event_set_q,
  input wire              oper_enable_clr_q,
  input wire [14:0]       warn_cond_q,
  input wire              warn_summary_q,
  input wire              lock_err_flag_q,
  input wire              err_avail_q
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire pop_w = cmd_valid && (cmd_op == 4'hE || cmd_op == 4'hF);

  cond_follow_a: assert property ($past(rst_n) |-> warn_cond_q == $past(warn_cond_in))
    else $error("condition copy lags wrong");
  // every event bit leaves one cycle after that input bit moved
  oper_edge_a: assert property ($past(rst_n, 2) |->
    (oper_event_set_q & ~($past(oper_cond_in) ^ $past(oper_cond_in, 2))) == 15'h0000)
    else $error("operational event without transition");
  preset_clr_a: assert property (cmd_valid && cmd_op == 4'h5 |=> oper_enable_clr_q)
    else $error("preset gave no enable clear");
  lock_sum_a: assert property (lock_err_flag_q |-> warn_summary_q)
    else $error("lock flag without summary");
  push_avail_a: assert property (err_push |=> err_avail_q)
    else $error("queue flag low after push");
  rsp_cause_a: assert property (cmd_valid && cmd_op != 4'h0 |=> rsp_valid_q)
    else $error("command gave no response");
  empty_pop_a: assert property (pop_w && !err_avail_q |=> rsp_code_q == 16'h0000 && rsp_desc_q == 8'h00)
    else $error("empty pop not code zero");
  code_hold_a: assert property (!pop_w |=> $stable(rsp_code_q))
    else $error("entry code moved without pop");

  cover property (pop_w && err_avail_q);
  cover property (oper_enable_clr_q);
  cover property (lock_err_flag_q);
endmodule

bind ssq_status ssq_status_checker #(.QDEPTH(QDEPTH), .PTR_W(PTR_W), .CODE_W(CODE_W), .DESC_W(DESC_W))
  u_ssq_status_checker (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
  .cmd_wdata(cmd_wdata), .oper_cond_in(oper_cond_in), .warn_cond_in(warn_cond_in), .err_push(err_push),
  .err_code(err_code), .err_desc(err_desc), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
  .rsp_code_q(rsp_code_q), .rsp_desc_q(rsp_desc_q), .oper_event_set_q(oper_event_set_q),
  .oper_enable_clr_q(oper_enable_clr_q), .warn_cond_q(warn_cond_q), .warn_summary_q(warn_summary_q),
  .lock_err_flag_q(lock_err_flag_q), .err_avail_q(err_avail_q));

/* File: tb/ssq_ctrl_model.sv */
// remote controller issuing one command at a time
// assumes the bench calls its tasks hierarchically
`timescale 1ns/1ps
module ssq_ctrl_model (
  output reg         cmd_valid,
  output reg  [3:0]  cmd_op,
  output reg  [14:0] cmd_wdata,
  input  wire        clk,
  input  wire [15:0] rsp_code_q
);
  initial begin
    cmd_valid = 1'b0;
    cmd_op = 4'h0;
    cmd_wdata = 15'h0000;
  end
  // idle lines flip so a stale value is never mistaken for a live one
  task issue(input [3:0] op, input [14:0] wd);
    @(negedge clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_wdata = wd;
    @(negedge clk);
    cmd_valid = 1'b0;
    cmd_op = ~op;
    cmd_wdata = ~wd;
  endtask
  // pops until code zero, bounded in case the queue never empties
  task drain(output integer n);
    n = 0;
    issue(4'hF, 15'h0000);
    while (rsp_code_q !== 16'h0000 && n < 12) begin
      n = n + 1;
      issue(4'hE, 15'h0000);
    end
  endtask
endmodule

/* File: tb/ssq_status_tb.sv */
// self-checking bench for the status block
// assumes the controller model and the bound checker
`timescale 1ns/1ps
module ssq_status_tb;
  reg         clk;
  reg         rst_n;
  wire        cmd_valid;
  wire [3:0]  cmd_op;
  wire [14:0] cmd_wdata;
  reg  [14:0] oper_cond_in;
  reg  [14:0] warn_cond_in;
  reg         err_push;
  reg  [15:0] err_code;
  reg  [7:0]  err_desc;
  wire        rsp_valid_q;
  wire [14:0] rsp_data_q;
  wire [15:0] rsp_code_q;
  wire [7:0]  rsp_desc_q;
  wire [14:0] oper_event_set_q;
  wire        oper_enable_clr_q;
  wire [14:0] warn_cond_q;
  wire        warn_summary_q;
  wire        lock_err_flag_q;
  wire        err_avail_q;
  integer     miscompares;
  integer     n_compared;
  integer     i;
  integer     n;
  reg  [14:0] ev;
  reg  [3:0]  op;

  ssq_status u_ssq_status (.clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_wdata(cmd_wdata), .oper_cond_in(oper_cond_in), .warn_cond_in(warn_cond_in), .err_push(err_push),
    .err_code(err_code), .err_desc(err_desc), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .rsp_code_q(rsp_code_q), .rsp_desc_q(rsp_desc_q), .oper_event_set_q(oper_event_set_q),
    .oper_enable_clr_q(oper_enable_clr_q), .warn_cond_q(warn_cond_q), .warn_summary_q(warn_summary_q),
    .lock_err_flag_q(lock_err_flag_q), .err_avail_q(err_avail_q));
  ssq_ctrl_model u_ssq_ctrl_model (.cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_wdata(cmd_wdata),
    .clk(clk), .rsp_code_q(rsp_code_q));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input [8*10:1] nm, input [15:0] got, input [15:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      miscompares = miscompares + 1;
      $display("unexpected %0s expected %h seen %h", nm, exp, got);
    end
  endtask
  task cmd(input [3:0] o, input [14:0] wd);
    u_ssq_ctrl_model.issue(o, wd);
    chk("rsp_valid", {15'h0000, rsp_valid_q}, 16'h0001);
  endtask
  task final_report;
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_masks(input [14:0] wv);
    for (i = 0; i < 5; i = i + 1) begin
      op = (i == 0) ? 4'h1 : (i == 1) ? 4'h3 : 4'h8 + 4'h2 * (i - 2);
      if (wv != 15'h0000) cmd(op, wv ^ i[14:0]);
      cmd(op + 4'h1, 15'h0000);
      ev = (wv != 15'h0000) ? wv ^ i[14:0] : ((i == 0 || i == 3) ? 15'h7FFF : 15'h0000);
      chk("mask_read", {1'b0, rsp_data_q}, {1'b0, ev});
    end
  endtask
  task t_oper;
    cmd(4'h1, 15'h0200);
    cmd(4'h3, 15'h0008);
    for (n = 0; n < 2; n = n + 1) begin
      @(negedge clk);
      oper_cond_in = n ? 15'h0210 : 15'h0018;
      ev = 15'h0000;
      repeat (3) @(negedge clk) ev = ev | oper_event_set_q;
      chk("oper_event", {1'b0, ev}, n ? 16'h0208 : 16'h0000);
    end
  endtask
  task t_warn;
    cmd(4'hA, 15'h0220);
    cmd(4'hC, 15'h0008);
    cmd(4'h8, 15'h0020);
    warn_cond_in = 15'h0008;
    repeat (3) @(negedge clk);
    cmd(4'h6, 15'h0000);
    chk("warn_ev0", {1'b0, rsp_data_q}, 16'h0000);
    warn_cond_in = 15'h0220;
    repeat (3) @(negedge clk);
    chk("lock_flag", {15'h0000, lock_err_flag_q}, 16'h0001);
    chk("warn_sum", {15'h0000, warn_summary_q}, 16'h0001);
    warn_cond_in = 15'h0020;
    cmd(4'h7, 15'h0000);
    chk("warn_cond", {1'b0, rsp_data_q}, 16'h0020);
    chk("cond_q", {1'b0, warn_cond_q}, 16'h0020);
    cmd(4'h6, 15'h0000);
    chk("warn_ev1", {1'b0, rsp_data_q}, 16'h0228);
    cmd(4'h6, 15'h0000);
    chk("warn_ev2", {1'b0, rsp_data_q}, 16'h0000);
    chk("lock_off", {15'h0000, lock_err_flag_q}, 16'h0000);
    chk("sum_off", {15'h0000, warn_summary_q}, 16'h0000);
  endtask
  task t_queue;
    for (i = 1; i <= 13; i = i + 1) begin
      @(negedge clk);
      err_push = (i != 12);
      err_code = i[15:0];
      err_desc = i[7:0];
    end
    @(negedge clk);
    err_push = 1'b0;
    chk("avail_on", {15'h0000, err_avail_q}, 16'h0001);
    for (i = 1; i <= 10; i = i + 1) begin
      cmd(i[0] ? 4'hE : 4'hF, 15'h0000);
      chk("pop_code", rsp_code_q, (i < 10) ? i[15:0] : 16'hFEA2);
      chk("pop_desc", {8'h00, rsp_desc_q}, (i < 10) ? i[15:0] : 16'h0001);
    end
    chk("avail_off", {15'h0000, err_avail_q}, 16'h0000);
    u_ssq_ctrl_model.drain(n);
    chk("drain_n", n[15:0], 16'h0000);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #(5 * 20000);
    miscompares = miscompares + 1;
    final_report;
  end
  initial begin
    {rst_n, err_push, err_code, err_desc, oper_cond_in, warn_cond_in} = 56'h0;
    miscompares = 0;
    n_compared = 0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    t_masks(15'h0000);
    t_masks(15'h7FFF);
    t_masks(15'h5555);
    cmd(4'h5, 15'h0000);
    chk("en_clr", {15'h0000, oper_enable_clr_q}, 16'h0001);
    t_masks(15'h0000);
    t_oper;
    t_warn;
    t_queue;
    final_report;
  end
endmodule
